// File: rtl/lcsel_pkg.sv
// constants, field layouts and carriers for the carry-select logic cluster
package lcsel_pkg;

   // cluster shape
   localparam int CELLS_DEF = 10;
   localparam int HALF      = 5;
   localparam int LUT_IN    = 4;
   localparam int LUT_W     = 16;
   localparam int ADDR_W    = 8;
   localparam int DATA_W    = 32;

   // apb register byte offsets
   localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_DAT0   = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_ARITH  = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_CSEL   = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_CSTART = 8'h1c;
   localparam logic [ADDR_W-1:0] OFS_LCHAIN = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_PACK   = 8'h24;
   localparam logic [ADDR_W-1:0] OFS_COMB   = 8'h28;
   localparam logic [ADDR_W-1:0] OFS_REGQ   = 8'h2c;
   localparam logic [ADDR_W-1:0] OFS_STAT   = 8'h30;
   localparam logic [ADDR_W-1:0] OFS_LUT0   = 8'h40;

   // control register fields
   localparam int CTRL_W     = 6;
   localparam int CTRL_ENA   = 0;
   localparam int CTRL_SCLR  = 1;
   localparam int CTRL_SLOAD = 2;
   localparam int CTRL_ALOAD = 3;
   localparam int CTRL_SUB   = 4;
   localparam int CTRL_CIN   = 5;
   localparam logic [CTRL_W-1:0] CTRL_RST = 6'h01;
   localparam logic [LUT_W-1:0]  LUT_RST  = 16'h0000;

   // per-cell static configuration
   typedef struct packed {
      logic [LUT_W-1:0] lut;
      logic             arith;
      logic             use_carry;
      logic             chain_start;
      logic             lut_chain;
      logic             packed_reg;
   } lcsel_cfg_s;

   // cluster-wide register controls
   typedef struct packed {
      logic ena;
      logic sclr;
      logic sload;
      logic aload;
      logic sub;
   } lcsel_ctrl_s;

   // precomputed carry pair
   typedef struct packed {
      logic c0;
      logic c1;
   } lcsel_carry_s;

endpackage : lcsel_pkg

// File: rtl/lcsel_cell.sv
// one logic cell: four-input lut, carry-select pair and output register
`timescale 1ns/1ns
module lcsel_cell (
   // clock and reset
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   // configuration and controls
   input  wire lcsel_pkg::lcsel_cfg_s  cfg,
   input  wire lcsel_pkg::lcsel_ctrl_s ctrl,
   // data and chains
   input  wire logic [3:0]            data,
   input  wire lcsel_pkg::lcsel_carry_s carry_in,
   input  wire logic                  blk_cin,
   input  wire logic                  chain_in,
   // results
   output logic                       comb,
   output logic                       q,
   output lcsel_pkg::lcsel_carry_s     carry_out
);
   import lcsel_pkg::*;

   logic       cx0;
   logic       cx1;
   logic       b_in;
   logic       res0;
   logic       res1;
   logic       res_n;
   logic       in2;
   logic       in3;
   logic       sel_c;
   logic       reg_d;
   logic       aset;
   logic       aclr;

   ////////////////////////////////////////////////////////////////////////
   // lut and carry-select datapath
   assign cx0   = cfg.chain_start ? ctrl.sub : carry_in.c0;
   assign cx1   = cfg.chain_start ? ctrl.sub : carry_in.c1;
   assign b_in  = data[1] ^ (cfg.arith & ctrl.sub);
   assign res0  = cfg.lut[{cx0, data[2], b_in, data[0]}];
   assign res1  = cfg.lut[{cx1, data[2], b_in, data[0]}];
   assign sel_c = blk_cin ? carry_in.c1 : carry_in.c0;
   assign in3   = cfg.use_carry ? sel_c : data[3];
   assign in2   = cfg.lut_chain ? chain_in : data[2];
   assign res_n = cfg.lut[{in3, in2, data[1], data[0]}];
   assign comb  = cfg.arith ? (blk_cin ? res1 : res0) : res_n;

   // both carry outcomes leave in parallel
   assign carry_out.c0 = cfg.arith &
      ((data[0] & b_in) | (cx0 & (data[0] ^ b_in)));
   assign carry_out.c1 = cfg.arith &
      ((data[0] & b_in) | (cx1 & (data[0] ^ b_in)));

   ////////////////////////////////////////////////////////////////////////
   // output register
   assign reg_d = cfg.packed_reg ? data[3] : comb;
   assign aset  = ctrl.aload & data[3];
   assign aclr  = ctrl.aload & ~data[3];

   always_ff @(posedge clk or negedge rst_n or posedge aset or posedge aclr) begin
      if (!rst_n) begin
         q <= 1'b0;
      end else if (aset) begin
         q <= 1'b1;
      end else if (aclr) begin
         q <= 1'b0;
      end else if (ctrl.ena) begin
         q <= ctrl.sclr ? 1'b0 : (ctrl.sload ? data[3] : reg_d);
      end
   end

endmodule : lcsel_cell

// File: rtl/lcsel_cluster.sv
// logic cluster of ten carry-select logic cells behind an apb slave
// Behaviour
// - cluster holds exactly ten chained cells
// - normal mode: four inputs feed one lut
// - static pick of carry or fourth input
// - lut output chains to next cell
// - asynchronous load takes fourth data input
// - cluster-wide register controls in every mode
// - packed register independent of lut
// - add/subtract select acts in arithmetic only
// - add/subtract drives first chain cell carry
// - arithmetic computes both carry cases
// - carry pair forwards to lut and chain
// - cluster carry-in selects; generated at five, ten
// - carry chain may start anywhere
`timescale 1ns/1ns
module lcsel_cluster #(
   parameter int N_CELLS = lcsel_pkg::CELLS_DEF
) (
   // clock and reset
   input  wire logic                          pclk,
   input  wire logic                          presetn,
   // apb slave
   input  wire logic [lcsel_pkg::ADDR_W-1:0]  paddr,
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [lcsel_pkg::DATA_W-1:0]  pwdata,
   output logic      [lcsel_pkg::DATA_W-1:0]  prdata,
   output logic                               pready,
   output logic                               pslverr,
   // cluster results
   output logic      [N_CELLS-1:0]            cell_q,
   output logic                               carry_out
);
   import lcsel_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // elaboration check
   if (N_CELLS != 2 * HALF) begin : g_bad_size
      $error("cluster must hold exactly ten cells");
   end

   ////////////////////////////////////////////////////////////////////////
   // register state
   logic [CTRL_W-1:0]            ctrl_reg;
   logic [3:0][N_CELLS-1:0]      dat_reg;
   logic [N_CELLS-1:0]           arith_reg;
   logic [N_CELLS-1:0]           csel_reg;
   logic [N_CELLS-1:0]           cstart_reg;
   logic [N_CELLS-1:0]           lchain_reg;
   logic [N_CELLS-1:0]           pack_reg;
   logic [N_CELLS-1:0][LUT_W-1:0] lut_reg;   // one writer process
   logic [DATA_W-1:0]            prdata_reg;
   logic                         pready_reg;
   logic                         pslverr_reg;
   logic                         cout_reg;

   // cell wiring
   lcsel_ctrl_s                  ctrl_w;
   lcsel_carry_s [N_CELLS-1:0]   cy_out;
   logic [N_CELLS-1:0]           comb_w;
   logic                         mid_cin;
   logic                         cluster_cout;

   ////////////////////////////////////////////////////////////////////////
   // apb decode
   logic                 setup;
   logic                 acc;
   logic                 wr;
   logic                 aligned;
   logic [ADDR_W-1:0]    lut_off;
   logic [ADDR_W-3:0]    lut_idx;
   logic                 hit_ctrl;
   logic                 hit_dat;
   logic [1:0]           dat_idx;
   logic [ADDR_W-1:0]    dat_off;
   logic                 hit_arith;
   logic                 hit_csel;
   logic                 hit_cstart;
   logic                 hit_lchain;
   logic                 hit_pack;
   logic                 hit_comb;
   logic                 hit_regq;
   logic                 hit_stat;
   logic                 hit_lut;
   logic                 mapped;
   logic [DATA_W-1:0]    rd_word;

   assign setup      = psel & ~penable;
   assign acc        = psel & penable & pready_reg;
   assign wr         = acc & pwrite;
   assign aligned    = (paddr[1:0] == 2'h0);
   assign lut_off    = paddr - OFS_LUT0;
   assign lut_idx    = lut_off[ADDR_W-1:2];
   assign dat_off    = paddr - OFS_DAT0;
   assign dat_idx    = dat_off[3:2];
   assign hit_ctrl   = aligned & (paddr == OFS_CTRL);
   assign hit_dat    = aligned & (paddr >= OFS_DAT0) & (paddr < OFS_ARITH);
   assign hit_arith  = aligned & (paddr == OFS_ARITH);
   assign hit_csel   = aligned & (paddr == OFS_CSEL);
   assign hit_cstart = aligned & (paddr == OFS_CSTART);
   assign hit_lchain = aligned & (paddr == OFS_LCHAIN);
   assign hit_pack   = aligned & (paddr == OFS_PACK);
   assign hit_comb   = aligned & (paddr == OFS_COMB);
   assign hit_regq   = aligned & (paddr == OFS_REGQ);
   assign hit_stat   = aligned & (paddr == OFS_STAT);
   assign hit_lut    = aligned & (paddr >= OFS_LUT0)
                       & (lut_idx < (ADDR_W-2)'(N_CELLS));
   assign mapped     = hit_ctrl | hit_dat | hit_arith | hit_csel
                       | hit_cstart | hit_lchain | hit_pack | hit_comb
                       | hit_regq | hit_stat | hit_lut;

   // read selection, narrow fields sit in the low bits
   assign rd_word =
      hit_ctrl   ? DATA_W'(ctrl_reg)              :
      hit_dat    ? DATA_W'(dat_reg[dat_idx])      :
      hit_arith  ? DATA_W'(arith_reg)             :
      hit_csel   ? DATA_W'(csel_reg)              :
      hit_cstart ? DATA_W'(cstart_reg)            :
      hit_lchain ? DATA_W'(lchain_reg)            :
      hit_pack   ? DATA_W'(pack_reg)              :
      hit_comb   ? DATA_W'(comb_w)                :
      hit_regq   ? DATA_W'(cell_q)                :
      hit_stat   ? DATA_W'(cout_reg)              :
      hit_lut    ? DATA_W'(lut_reg[lut_idx])      :
                   '0;

   ////////////////////////////////////////////////////////////////////////
   // apb answer: one wait-free access phase after every setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= '0;
      end else begin
         pready_reg  <= setup;
         pslverr_reg <= setup & ~mapped;
         prdata_reg  <= (setup & mapped & ~pwrite) ? rd_word : '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // control and mode registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= CTRL_RST;
      end else if (wr & hit_ctrl) begin
         ctrl_reg <= pwdata[CTRL_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         arith_reg  <= '0;
         csel_reg   <= '0;
         cstart_reg <= '0;
      end else begin
         if (wr & hit_arith)  arith_reg  <= pwdata[N_CELLS-1:0];
         if (wr & hit_csel)   csel_reg   <= pwdata[N_CELLS-1:0];
         if (wr & hit_cstart) cstart_reg <= pwdata[N_CELLS-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lchain_reg <= '0;
         pack_reg   <= '0;
      end else begin
         if (wr & hit_lchain) lchain_reg <= pwdata[N_CELLS-1:0];
         if (wr & hit_pack)   pack_reg   <= pwdata[N_CELLS-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dat_reg <= '0;
      end else if (wr & hit_dat) begin
         dat_reg[dat_idx] <= pwdata[N_CELLS-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lut_reg <= {N_CELLS{LUT_RST}};
      end else if (wr & hit_lut) begin
         lut_reg[lut_idx] <= pwdata[LUT_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cout_reg <= 1'b0;
      end else begin
         cout_reg <= cluster_cout;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // cells, carry-select blocks of five
   assign ctrl_w.ena   = ctrl_reg[CTRL_ENA];
   assign ctrl_w.sclr  = ctrl_reg[CTRL_SCLR];
   assign ctrl_w.sload = ctrl_reg[CTRL_SLOAD];
   assign ctrl_w.aload = ctrl_reg[CTRL_ALOAD];
   assign ctrl_w.sub   = ctrl_reg[CTRL_SUB];

   // carry generated at the fifth and tenth cells
   assign mid_cin = ctrl_reg[CTRL_CIN] ? cy_out[HALF-1].c1
                                       : cy_out[HALF-1].c0;
   assign cluster_cout = mid_cin ? cy_out[N_CELLS-1].c1
                                 : cy_out[N_CELLS-1].c0;

   for (genvar i = 0; i < N_CELLS; i++) begin : g_cell
      lcsel_cfg_s   cfg_w;
      lcsel_carry_s cin_w;
      logic         blk_w;
      logic         chain_w;

      assign cfg_w.lut         = lut_reg[i];
      assign cfg_w.arith       = arith_reg[i];
      assign cfg_w.use_carry   = csel_reg[i];
      assign cfg_w.chain_start = cstart_reg[i];
      assign cfg_w.lut_chain   = lchain_reg[i];
      assign cfg_w.packed_reg  = pack_reg[i];

      // block heads assume both carry values afresh
      if (i == 0 || i == HALF) begin : g_head
         assign cin_w.c0 = 1'b0;
         assign cin_w.c1 = 1'b1;
         // cell 0 has no lower neighbour to chain from
         if (i == 0) begin : g_first
            assign chain_w = 1'b0;
         end else begin : g_mid
            assign chain_w = comb_w[i-1];
         end
      end else begin : g_body
         assign cin_w   = cy_out[i-1];
         assign chain_w = comb_w[i-1];
      end
      assign blk_w = (i < HALF) ? ctrl_reg[CTRL_CIN] : mid_cin;

      lcsel_cell u_cell (
         .clk       (pclk),
         .rst_n     (presetn),
         .cfg       (cfg_w),
         .ctrl      (ctrl_w),
         .data      ({dat_reg[3][i], dat_reg[2][i],
                      dat_reg[1][i], dat_reg[0][i]}),
         .carry_in  (cin_w),
         .blk_cin   (blk_w),
         .chain_in  (chain_w),
         .comb      (comb_w[i]),
         .q         (cell_q[i]),
         .carry_out (cy_out[i])
      );
   end

   assign prdata    = prdata_reg;
   assign pready    = pready_reg;
   assign pslverr   = pslverr_reg;
   assign carry_out = cout_reg;

   ////////////////////////////////////////////////////////////////////////
   // assertions
   logic                 sub_w;
   logic [N_CELLS:0]     exp_sum;
   logic                 full_add;

   assign sub_w    = ctrl_reg[CTRL_SUB];
   assign exp_sum  = {1'b0, dat_reg[0]}
                     + {1'b0, dat_reg[1] ^ {N_CELLS{sub_w}}}
                     + {{N_CELLS{1'b0}}, sub_w};
   assign full_add = (arith_reg == {N_CELLS{1'b1}})
                     & (cstart_reg == N_CELLS'(1));

   AST_LUT_NORMAL: assert property (
      @(posedge pclk) disable iff (!presetn)
      (!arith_reg[0] && !csel_reg[0] && !lchain_reg[0])
      |-> comb_w[0] == lut_reg[0][{dat_reg[3][0], dat_reg[2][0],
                                   dat_reg[1][0], dat_reg[0][0]}])
      else $error("normal lut output wrong");

   AST_CARRY_PICK: assert property (
      @(posedge pclk) disable iff (!presetn)
      (!arith_reg[0] && csel_reg[0] && !lchain_reg[0])
      |-> comb_w[0] == lut_reg[0][{ctrl_reg[CTRL_CIN], dat_reg[2][0],
                                   dat_reg[1][0], dat_reg[0][0]}])
      else $error("carry not used as lut input");

   AST_LUT_CHAIN: assert property (
      @(posedge pclk) disable iff (!presetn)
      (!arith_reg[1] && !csel_reg[1] && lchain_reg[1])
      |-> comb_w[1] == lut_reg[1][{dat_reg[3][1], comb_w[0],
                                   dat_reg[1][1], dat_reg[0][1]}])
      else $error("lut chain not taken");

   AST_ALOAD: assert property (
      @(posedge pclk) disable iff (!presetn)
      ctrl_reg[CTRL_ALOAD] |-> cell_q == dat_reg[3])
      else $error("asynchronous load data wrong");

   AST_SYNC_CLEAR: assert property (
      @(posedge pclk) disable iff (!presetn)
      (ctrl_reg[CTRL_ENA] && ctrl_reg[CTRL_SCLR] && !ctrl_reg[CTRL_ALOAD])
      |=> ctrl_reg[CTRL_ALOAD] || cell_q == '0)
      else $error("synchronous clear missed");

   AST_HOLD: assert property (
      @(posedge pclk) disable iff (!presetn)
      (!ctrl_reg[CTRL_ENA] && !ctrl_reg[CTRL_ALOAD])
      ##1 !ctrl_reg[CTRL_ALOAD] |-> $stable(cell_q))
      else $error("register changed while disabled");

   AST_PACKED: assert property (
      @(posedge pclk) disable iff (!presetn)
      (pack_reg[0] && ctrl_reg[CTRL_ENA] && !ctrl_reg[CTRL_SCLR]
       && !ctrl_reg[CTRL_SLOAD] && !ctrl_reg[CTRL_ALOAD])
      ##1 !ctrl_reg[CTRL_ALOAD] |-> cell_q[0] == $past(dat_reg[3][0]))
      else $error("packed register data wrong");

   AST_CHAIN_START: assert property (
      @(posedge pclk) disable iff (!presetn)
      (arith_reg[3] && cstart_reg[3])
      |-> comb_w[3] == lut_reg[3][{sub_w, dat_reg[2][3],
                                   dat_reg[1][3] ^ sub_w, dat_reg[0][3]}])
      else $error("chain start cell wrong");

   AST_CLUSTER_COUT: assert property (
      @(posedge pclk) disable iff (!presetn)
      full_add |=> cout_reg == $past(exp_sum[N_CELLS]))
      else $error("cluster carry out wrong");

   AST_APB_READY: assert property (
      @(posedge pclk) disable iff (!presetn)
      (psel && !penable) |=> pready ##1 !pready)
      else $error("apb ready timing wrong");

   COV_ADD: cover property (@(posedge pclk) disable iff (!presetn)
      full_add && !sub_w && exp_sum[N_CELLS]);
   COV_SUB: cover property (@(posedge pclk) disable iff (!presetn)
      full_add && sub_w);
   COV_ALOAD: cover property (@(posedge pclk) disable iff (!presetn)
      ctrl_reg[CTRL_ALOAD] && dat_reg[3] != '0);
   COV_ERR: cover property (@(posedge pclk) disable iff (!presetn)
      pready && pslverr);

endmodule : lcsel_cluster

// File: testbench/lcsel_nbr.sv
// neighbouring cluster model that takes the carry and register outputs
`timescale 1ns/1ns
module lcsel_nbr (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // from the cluster under test
   input  wire logic [9:0] q_in,
   input  wire logic       cin,
   // what the neighbour has captured
   output logic      [9:0] q_seen,
   output logic            cin_seen
);
   // neighbour registers the cluster outputs at each rising edge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q_seen   <= '0;
         cin_seen <= 1'b0;
      end else begin
         q_seen   <= q_in;
         cin_seen <= cin;
      end
   end
endmodule : lcsel_nbr

// File: testbench/testbench.sv
// self-checking bench for the carry-select logic cluster
`timescale 1ns/1ns
module testbench;
   import lcsel_pkg::*;
   logic                 pclk, presetn, psel, penable, pwrite, err;
   logic [ADDR_W-1:0]    paddr;
   logic [DATA_W-1:0]    pwdata, prdata, rd;
   logic                 pready, pslverr, carry_out, nbr_cin;
   logic [CELLS_DEF-1:0] cell_q, nbr_q;
   int                   num_errors, total_checks;

   lcsel_cluster #(.N_CELLS(CELLS_DEF)) dut (.pclk(pclk), .presetn(presetn),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cell_q(cell_q), .carry_out(carry_out));
   lcsel_nbr nbr (.clk(pclk), .rst_n(presetn), .q_in(cell_q),
      .cin(carry_out), .q_seen(nbr_q), .cin_seen(nbr_cin));

   always #5 pclk = ~pclk;

   ////////////////////////////////////////////////////////////////////////
   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : finish_test

   task automatic cmp(input logic [DATA_W-1:0] got, exp, input string m);
      total_checks++;
      if (got !== exp) begin
         $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
         num_errors++;
      end
   endtask : cmp

   // one apb transfer; waits for pready under a bound
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         $display("[FAIL] %0t no pready", $time);
         num_errors++;
         finish_test();
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic chk(input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] e, input string m);
      apb(1'b0, a, '0);
      cmp(rd, e, m);
      cmp({31'h0, err}, 32'h0, "unexpected slave error");
   endtask : chk

   task automatic chk_err(input logic w, input logic [ADDR_W-1:0] a);
      apb(w, a, 32'h5);
      cmp({31'h0, err}, 32'h1, "slave error missing");
      cmp(rd, 32'h0, "refused read data");
   endtask : chk_err

   // adds a and b over the chain from cell st upward
   task automatic addt(input int st, input logic s,
                       input logic [9:0] a, input logic [9:0] b);
      logic [10:0] sum;
      logic [9:0]  m;
      int          w;
      m = 10'h3ff << st;
      w = 10 - st;
      sum = {1'b0, a >> st} + {1'b0, (s ? ~b : b) >> st} + {10'h0, s};
      wr(OFS_ARITH, 32'(m));
      wr(OFS_CSTART, 32'(10'h1 << st));
      wr(OFS_CTRL, {27'h0, s, 4'h1});
      wr(OFS_DAT0, 32'(a));
      wr(OFS_DAT0 + 8'h04, 32'(b));
      apb(1'b0, OFS_COMB, '0);
      cmp(rd & 32'(m), (32'(sum) << st) & 32'(m), "sum");
      chk(OFS_STAT, {31'h0, sum[w]}, "carry out");
      cmp({31'h0, nbr_cin}, {31'h0, sum[w]}, "carry seen by neighbour");
   endtask : addt

   ////////////////////////////////////////////////////////////////////////
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      num_errors = 0;
      total_checks = 0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      chk(OFS_CTRL, 32'h1, "ctrl reset");
      chk(OFS_LUT0, 32'h0, "lut reset");
      chk(OFS_REGQ, 32'h0, "register reset");
      chk_err(1'b1, 8'h34);
      chk_err(1'b0, 8'h3c);
      chk_err(1'b0, 8'h02);
      $display("test reset and refusals done");
      // normal mode: every lut passes its first input
      for (int i = 0; i < CELLS_DEF; i++)
         wr(OFS_LUT0 + ADDR_W'(4 * i), 32'haaaa);
      wr(OFS_DAT0, 32'h2aa);
      wr(OFS_DAT0 + 8'h0c, 32'h0f0);
      chk(OFS_COMB, 32'h2aa, "lut output");
      chk(OFS_REGQ, 32'h2aa, "register takes lut");
      wr(OFS_CTRL, 32'h05);
      chk(OFS_REGQ, 32'h0f0, "sync load");
      wr(OFS_CTRL, 32'h03);
      chk(OFS_REGQ, 32'h0, "sync clear");
      wr(OFS_CTRL, 32'h00);
      chk(OFS_REGQ, 32'h0, "enable off holds");
      wr(OFS_CTRL, 32'h08);
      chk(OFS_REGQ, 32'h0f0, "async load");
      wr(OFS_DAT0 + 8'h0c, 32'h30c);
      chk(OFS_REGQ, 32'h30c, "async load follows");
      wr(OFS_CTRL, 32'h01);
      wr(OFS_PACK, 32'h3ff);
      chk(OFS_REGQ, 32'h30c, "packed register");
      chk(OFS_COMB, 32'h2aa, "lut beside packed");
      cmp({22'h0, cell_q}, 32'h30c, "cell_q port");
      cmp({22'h0, nbr_q}, 32'h30c, "neighbour register view");
      wr(OFS_PACK, 32'h0);
      wr(OFS_CTRL, 32'h11);
      chk(OFS_COMB, 32'h2aa, "subtract ignored");
      // cell 1 passes its third input; chain swaps in cell 0
      wr(OFS_LUT0 + 8'h04, 32'hf0f0);
      wr(OFS_DAT0, 32'h2ab);
      wr(OFS_DAT0 + 8'h08, 32'h0);
      chk(OFS_COMB, 32'h2a9, "no lut chain");
      wr(OFS_LCHAIN, 32'h002);
      chk(OFS_COMB, 32'h2ab, "lut chain");
      wr(OFS_LCHAIN, 32'h0);
      $display("test normal mode done");
      // sum lut: first, second and carry inputs exclusive-or
      for (int i = 0; i < CELLS_DEF; i++)
         wr(OFS_LUT0 + ADDR_W'(4 * i), 32'h9966);
      addt(0, 1'b0, 10'h3ff, 10'h001);
      addt(0, 1'b0, 10'h155, 10'h0ab);
      addt(0, 1'b1, 10'h005, 10'h003);
      addt(0, 1'b1, 10'h003, 10'h005);
      addt(4, 1'b0, 10'h3f0, 10'h010);
      addt(4, 1'b1, 10'h100, 10'h200);
      addt(3, 1'b1, 10'h208, 10'h038);
      wr(OFS_CTRL, 32'h03);
      chk(OFS_REGQ, 32'h0, "sync clear in arithmetic");
      // no start cell: the cluster carry-in feeds cell 0
      wr(OFS_CSTART, 32'h0);
      wr(OFS_ARITH, 32'h3ff);
      wr(OFS_DAT0, 32'h3ff);
      wr(OFS_DAT0 + 8'h04, 32'h0);
      wr(OFS_CTRL, 32'h21);
      chk(OFS_COMB, 32'h0, "carry-in one sum");
      chk(OFS_STAT, 32'h1, "carry-in one carry out");
      wr(OFS_CTRL, 32'h01);
      chk(OFS_COMB, 32'h3ff, "carry-in zero sum");
      chk(OFS_STAT, 32'h0, "carry-in zero carry out");
      // normal mode: cell 0 takes the carry in place of input 3
      wr(OFS_ARITH, 32'h0);
      wr(OFS_CSEL, 32'h001);
      chk(OFS_COMB, 32'h0f3, "carry pick, carry zero");
      wr(OFS_CTRL, 32'h21);
      chk(OFS_COMB, 32'h0f2, "carry pick, carry one");
      wr(OFS_CSEL, 32'h0);
      $display("test arithmetic done");
      finish_test();
   end
endmodule : testbench
